// ### wbsu_pkg.sv
// shared constants and carrier types for the 60-bit boolean and shift unit
package wbsu_pkg;

  // word and field widths
  localparam int WBSU_WORD_W = 60;
  localparam int WBSU_IDX_W = 18;
  localparam int WBSU_OP_W = 6;
  localparam int WBSU_DES_W = 3;
  localparam int WBSU_IMM_W = 6;
  localparam int WBSU_NEG_CNT_W = 12;

  // operation codes of the handled instructions
  localparam logic [5:0] WBSU_OP_DIFF_COMP = 6'h0F;
  localparam logic [5:0] WBSU_OP_ROT_IMM = 6'h10;
  localparam logic [5:0] WBSU_OP_SRA_IMM = 6'h11;
  localparam logic [5:0] WBSU_OP_IDX_SHIFT = 6'h12;

  // index register field positions
  localparam int WBSU_IDX_SIGN_POS = 17;
  localparam int WBSU_IDX_CNT_HI = 5;
  localparam int WBSU_IDX_OVF_LO = 6;
  localparam int WBSU_IDX_OVF_HI_BASE = 10;
  localparam int WBSU_IDX_OVF_HI_EXT = 11;
  localparam int WBSU_WORD_SIGN_POS = 59;

  // rotate modulus and fixed results
  localparam logic [5:0] WBSU_ROT_MOD = 6'h3C;
  localparam logic [11:0] WBSU_SRA_FULL = 12'h03C;
  localparam logic [59:0] WBSU_POS_ZERO = 60'h000000000000000;
  localparam logic [59:0] WBSU_NEG_ZERO = 60'hFFFFFFFFFFFFFFF;
  localparam logic [17:0] WBSU_IDX_POS_ZERO = 18'h00000;
  localparam logic [17:0] WBSU_IDX_NEG_ZERO = 18'h3FFFF;

  // cycles from issue to result, the same for every operand value
  localparam int WBSU_LATENCY = 1;

  // decoded class of the issued instruction
  typedef enum logic [2:0] {
    WBSU_CLS_NONE = 3'b000,
    WBSU_CLS_DIFF_COMP = 3'b001,
    WBSU_CLS_ROT_IMM = 3'b010,
    WBSU_CLS_SRA_IMM = 3'b011,
    WBSU_CLS_IDX_SHIFT = 3'b100
  } wbsu_class_t;

  // instruction fields from the issue logic
  typedef struct packed {
    logic valid;
    logic [5:0] operation_code_field;
    logic [2:0] i_des;
    logic [2:0] j_des;
    logic [2:0] k_des;
  } wbsu_instr_t;

  // operand words read from the register files
  typedef struct packed {
    logic [59:0] result_operand_register;
    logic [59:0] first_source_register;
    logic [59:0] second_source_register;
    logic [17:0] shift_count_index_register;
  } wbsu_operands_t;

  // write-back to the operand register file
  typedef struct packed {
    logic write_en;
    logic unsupported;
    logic [2:0] dest_des;
    logic [59:0] data;
  } wbsu_result_t;

endpackage

// ### wbsu_unit.sv
// single-cycle 60-bit boolean and shift datapath with write-back register
`timescale 1ns/100ps

// Notes on behaviour
// - result is first xor inverted second
// - immediate left rotate rewrites result register
// - j and k form 6-bit count
// - rotate reinserts high bits at low end
// - immediate right shift rewrites result register
// - right shift fills with original sign
// - index bit 17 picks shift direction
// - base overflow gives positive zero
// - extended overflow gives negative zero
// - extended zero index passes source unchanged
// - extended rotate count low six mod 60
// - extended right count inverted low twelve
// - all-ones or zeros words shift normally
module wbsu_unit import wbsu_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic extended_model_in,
  input wire wbsu_instr_t instr_in,
  input wire wbsu_operands_t operands_in,
  output wbsu_result_t result_out
);

  // issue timing, seen from the ports:
  //   cycle 0  issue strobe, code, designators and operands all present
  //   edge 1   write strobe or refusal flag, designator and data registered
  //   cycle 2  strobes drop again unless another issue was taken at edge 2
  // one instruction per cycle, back to back, with no spacing needed
  // no forwarding inside: a result written at edge 1 is not seen by an
  // instruction issued in cycle 1 unless the issue logic supplies it
  //
  // index operand layout, 18 bits, ones-complement:
  //   bit 17       sign, picks the direction
  //   bits 16..12  read only by the zero-index compare of the extended variant
  //   bit 11       overflow field of the extended variant only
  //   bits 10..6   overflow field of both variants
  //   bits 5..0    rotate count, or inverted right count
  //
  // positive index, both variants:
  //   rotate left by the low six bits, counts 60..63 fold to 0..3
  // negative index, base variant:
  //   overflow field not all ones gives positive zero
  //   otherwise right shift by the inverted low six bits
  // negative index, extended variant:
  //   overflow field not all ones gives negative zero
  //   otherwise right shift by the inverted low twelve bits
  //   both zero codes pass the source word through untouched
  //
  // immediate shifts work in place: the destination word is both the
  // operand and the target, so the issue logic must present it as the
  // result operand and not as one of the two sources
  //
  // every path is plain gates into one register, so the time to the
  // write strobe never depends on the code, the count or the data;
  // the price is a wide barrel of muxes in front of the register

  // left circular rotate, count folded into 0..59
  function automatic logic [59:0] wbsu_rotl(
    input logic [59:0] word,
    input logic [5:0] cnt
  );
    logic [5:0] folded;
    logic [119:0] doubled;
    // a 6-bit count exceeds 59 by at most 4, so one subtraction folds it
    folded = (cnt >= WBSU_ROT_MOD) ? cnt - WBSU_ROT_MOD : cnt;
    // doubling the word lets a plain shift carry the top bits round
    doubled = {word, word} << folded;
    // upper half holds the rotated word, no bit lost or reordered
    return doubled[119:60];
  endfunction

  // arithmetic right shift, wide counts saturate to all sign
  function automatic logic [59:0] wbsu_sra(
    input logic [59:0] word,
    input logic [11:0] cnt
  );
    logic [59:0] fill;
    logic [59:0] shifted;
    fill = {WBSU_WORD_W{word[WBSU_WORD_SIGN_POS]}};
    // the signed view makes the shift copy bit 59 into vacated places
    shifted = $signed(word) >>> cnt;
    // counts of 60 or more leave nothing but sign copies
    return (cnt >= WBSU_SRA_FULL) ? fill : shifted;
  endfunction

  // handled codes, in octal:
  //   17  logical difference with complement
  //   20  immediate left rotate, in place
  //   21  immediate right arithmetic shift, in place
  //   22  index-register shift, direction from the index sign
  // every other code is refused with the flag and writes nothing

  // map an operation code to its class; other codes are not ours
  function automatic wbsu_class_t wbsu_decode(
    input logic [5:0] op
  );
    wbsu_class_t cls;
    unique case (op)
      WBSU_OP_DIFF_COMP: cls = WBSU_CLS_DIFF_COMP;
      WBSU_OP_ROT_IMM: cls = WBSU_CLS_ROT_IMM;
      WBSU_OP_SRA_IMM: cls = WBSU_CLS_SRA_IMM;
      WBSU_OP_IDX_SHIFT: cls = WBSU_CLS_IDX_SHIFT;
      default: cls = WBSU_CLS_NONE;
    endcase
    return cls;
  endfunction

  // registered write-back and its next value
  wbsu_result_t result_ff;
  wbsu_result_t nxt_result;

  // decoded fields of the issued instruction
  wbsu_class_t op_class;
  wire logic issue_valid;
  wire logic [2:0] dest_des;
  wire logic [5:0] immediate_shift_count;
  wire logic supported;

  // the issue logic has already split the parcel into fields
  assign issue_valid = instr_in.valid;
  assign op_class = wbsu_decode(instr_in.operation_code_field);
  assign dest_des = instr_in.i_des;
  assign supported = (op_class != WBSU_CLS_NONE);

  // one-hot class strobes for the and-or result select
  wire logic cls_diff;
  wire logic cls_rot_imm;
  wire logic cls_sra_imm;
  wire logic cls_idx;

  assign cls_diff = (op_class == WBSU_CLS_DIFF_COMP);
  assign cls_rot_imm = (op_class == WBSU_CLS_ROT_IMM);
  assign cls_sra_imm = (op_class == WBSU_CLS_SRA_IMM);
  assign cls_idx = (op_class == WBSU_CLS_IDX_SHIFT);

  // immediate count is j then k, unsigned
  assign immediate_shift_count = {instr_in.j_des, instr_in.k_des};

  // operand words
  wire logic [59:0] result_operand_register;
  wire logic [59:0] first_source_register;
  wire logic [59:0] second_source_register;
  wire logic [17:0] shift_count_index_register;

  assign result_operand_register = operands_in.result_operand_register;
  assign first_source_register = operands_in.first_source_register;
  assign second_source_register = operands_in.second_source_register;
  assign shift_count_index_register = operands_in.shift_count_index_register;

  // logical difference with complement, bit by bit
  wire logic [59:0] diff_comp_word;

  assign diff_comp_word = first_source_register ^ ~second_source_register;

  // in-place immediate shifts read and rewrite the result register
  wire logic [59:0] rot_imm_word;
  wire logic [59:0] sra_imm_word;
  wire logic [11:0] imm_sra_cnt;

  // a 6-bit count never needs saturation beyond 63
  assign imm_sra_cnt = {6'h00, immediate_shift_count};
  assign rot_imm_word = wbsu_rotl(result_operand_register, immediate_shift_count);
  assign sra_imm_word = wbsu_sra(result_operand_register, imm_sra_cnt);

  // index register fields; the sign and low count are shared by both variants
  wire logic idx_sign;
  wire logic [5:0] idx_low_cnt;
  wire logic [5:0] idx_low_inv;
  wire logic [11:0] idx_low12_inv;

  assign idx_sign = shift_count_index_register[WBSU_IDX_SIGN_POS];
  assign idx_low_cnt = shift_count_index_register[WBSU_IDX_CNT_HI:0];
  assign idx_low_inv = ~idx_low_cnt;
  assign idx_low12_inv = ~shift_count_index_register[WBSU_NEG_CNT_W-1:0];

  // base variant: bits 11 to 16 are never looked at
  wire logic [4:0] base_ovf_field;
  wire logic base_ovf;
  wire logic [11:0] base_neg_cnt;
  wire logic [59:0] base_rot_word;
  wire logic [59:0] base_sra_word;
  wire logic [59:0] base_word;

  assign base_ovf_field =
    shift_count_index_register[WBSU_IDX_OVF_HI_BASE:WBSU_IDX_OVF_LO];
  assign base_ovf = idx_sign & (base_ovf_field != {5{idx_sign}});
  // ones-complement index, so the count is the inverted low bits
  assign base_neg_cnt = {6'h00, idx_low_inv};
  assign base_rot_word = wbsu_rotl(second_source_register, idx_low_cnt);
  assign base_sra_word = wbsu_sra(second_source_register, base_neg_cnt);

  // overflow beats the shift so a huge count cannot leak sign bits
  assign base_word = !idx_sign ? base_rot_word :
                     base_ovf ? WBSU_POS_ZERO :
                     base_sra_word;

  // extended variant: bits 12 to 16 are looked at only by the zero-index compare
  wire logic [5:0] ext_ovf_field;
  wire logic ext_ovf;
  wire logic ext_zero;
  wire logic [59:0] ext_rot_word;
  wire logic [59:0] ext_sra_word;
  wire logic [59:0] ext_word;

  assign ext_ovf_field =
    shift_count_index_register[WBSU_IDX_OVF_HI_EXT:WBSU_IDX_OVF_LO];
  assign ext_ovf = idx_sign & (ext_ovf_field != {6{idx_sign}});
  wire logic ext_pos_zero;
  wire logic ext_neg_zero;

  // both ones-complement zeros copy the source
  assign ext_pos_zero = (shift_count_index_register == WBSU_IDX_POS_ZERO);
  assign ext_neg_zero = (shift_count_index_register == WBSU_IDX_NEG_ZERO);
  assign ext_zero = ext_pos_zero | ext_neg_zero;
  assign ext_rot_word = wbsu_rotl(second_source_register, idx_low_cnt);
  // counts of 60 or more saturate to a word of sign copies
  assign ext_sra_word = wbsu_sra(second_source_register, idx_low12_inv);

  // zero index is a plain copy, still through the same pipeline stage
  assign ext_word = ext_zero ? second_source_register :
                    !idx_sign ? ext_rot_word :
                    ext_ovf ? WBSU_NEG_ZERO :
                    ext_sra_word;

  // variant select; the model strap is static while instructions run
  // limitation: the strap is read on every issue, so flipping it while
  // a program runs changes what a negative index means; the issue
  // logic must hold it steady between programs
  wire logic [59:0] idx_shift_word;

  assign idx_shift_word = extended_model_in ? ext_word : base_word;

  // result select as an and-or of masked words; no data-dependent
  // path, so all-ones and all-zeros words take the same single cycle
  // as any other value
  wire logic [59:0] diff_term;
  wire logic [59:0] rot_imm_term;
  wire logic [59:0] sra_imm_term;
  wire logic [59:0] idx_term;
  wire logic [59:0] sel_word;

  assign diff_term = diff_comp_word & {WBSU_WORD_W{cls_diff}};
  assign rot_imm_term = rot_imm_word & {WBSU_WORD_W{cls_rot_imm}};
  assign sra_imm_term = sra_imm_word & {WBSU_WORD_W{cls_sra_imm}};
  assign idx_term = idx_shift_word & {WBSU_WORD_W{cls_idx}};

  // a refused code leaves every mask low, so its word is zero
  assign sel_word = diff_term | rot_imm_term | sra_imm_term | idx_term;

  // next write-back; unknown codes raise a flag and write nothing
  wire logic nxt_write_en;
  wire logic nxt_unsupported;

  assign nxt_write_en = issue_valid & supported;
  assign nxt_unsupported = issue_valid & !supported;
  // one pattern drives the whole struct, so it has a single driver
  assign nxt_result = '{write_en: nxt_write_en, unsupported: nxt_unsupported,
                        dest_des: dest_des, data: sel_word};

  // one register stage; reset clears the whole word, strobes included
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      result_ff <= '0;
    end else begin
      result_ff <= nxt_result;
    end
  end

  // write-back straight from the register
  assign result_out = result_ff;

endmodule

// ### wbsu_issue_model.sv
// issue logic model: splits a 15-bit instruction and presents its operands
`timescale 1ns/100ps
module wbsu_issue_model import wbsu_pkg::*; (
  input wire logic mclk_in,
  input wire logic issue_in,
  input wire logic [14:0] word_in,
  input wire wbsu_operands_t ops_in,
  output wbsu_instr_t instr_out,
  output wbsu_operands_t operands_out
);
  wbsu_operands_t last_ff;
  // idle cycles show inverted stale operands so the unit cannot lean on them
  always_ff @(posedge mclk_in) begin
    last_ff <= operands_out;
  end
  // code in bits 14..9, then destination, j and k designators
  assign instr_out = {issue_in, word_in};
  assign operands_out = issue_in ? ops_in : ~last_ff;
endmodule

// ### wbsu_unit_properties.sv
// concurrent checks on the unit's ports
`timescale 1ns/100ps
module wbsu_unit_properties import wbsu_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic extended_model_in,
  input wire wbsu_instr_t instr_in,
  input wire wbsu_operands_t operands_in,
  input wire wbsu_result_t result_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // decoded issue conditions
  wire logic [5:0] op = instr_in.operation_code_field;
  wire logic [17:0] b = operands_in.shift_count_index_register;
  wire logic [59:0] src = operands_in.second_source_register;
  wire logic [59:0] dst = operands_in.result_operand_register;
  wire logic ix = instr_in.valid && op == 6'h12;
  wire logic x = extended_model_in;
  wire logic [59:0] d = result_out.data;
  AST_WRITE: assert property (instr_in.valid && op >= 6'h0F && op <= 6'h12 |=>
    result_out.write_en && result_out.dest_des == $past(instr_in.i_des)) else $error("no write");
  AST_DIFF: assert property (instr_in.valid && op == 6'h0F |=>
    d == ($past(operands_in.first_source_register) ^ ~$past(src))) else $error("bad difference");
  AST_ROT: assert property (instr_in.valid && op == 6'h10 |=>
    $countones(d) == $countones($past(dst))) else $error("rotate lost bits");
  AST_IMM63: assert property (instr_in.valid && op == 6'h11 &&
    {instr_in.j_des, instr_in.k_des} == 6'h3F |=> d == {60{$past(dst[59])}}) else $error("bad fill");
  AST_DIR: assert property (ix && !b[17] |=>
    $countones(d) == $countones($past(src))) else $error("wrong direction");
  AST_BOVF: assert property (ix && !x && b[17] && b[10:6] != 5'h1F |=> d == '0)
    else $error("base overflow not zero");
  AST_EOVF: assert property (ix && x && b[17] && b[11:6] != 6'h3F |=> d == '1)
    else $error("extended overflow not ones");
  AST_EZERO: assert property (ix && x && (b == 18'h00000 || b == 18'h3FFFF) |=>
    d == $past(src)) else $error("zero index altered word");
  AST_ROT63: assert property (ix && !b[17] && b[5:0] == 6'h3F |=>
    d == {$past(src[56:0]), $past(src[59:57])}) else $error("count 63 not three");
  AST_REFUSE: assert property (instr_in.valid && (op < 6'h0F || op > 6'h12) |=>
    result_out.unsupported && !result_out.write_en && d == '0) else $error("code not refused");
  AST_IDLE: assert property (!instr_in.valid |=>
    !result_out.write_en && !result_out.unsupported) else $error("strobe without issue");
  AST_EFULL: assert property (ix && x && b[17] && b[11:6] == 6'h3F && b[5:0] <= 6'h03 |=>
    d == {60{$past(src[59])}}) else $error("wide count not all sign");
  AST_BNEG1: assert property (ix && !x && b[17] && b[10:6] == 5'h1F && b[5:0] == 6'h3E |=>
    d == {$past(src[59]), $past(src[59:1])}) else $error("base negative count wrong");
endmodule
bind wbsu_unit wbsu_unit_properties u_props (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .extended_model_in(extended_model_in), .instr_in(instr_in), .operands_in(operands_in),
  .result_out(result_out));

// ### word60_boolean_shift_unit_tb.sv
// self-checking random bench for the boolean and shift unit
`timescale 1ns/100ps
module word60_boolean_shift_unit_tb import wbsu_pkg::*;;
  logic mclk_in, rstn_in, ext, issue, exp_v, exp_u;
  logic [14:0] iword;
  logic [2:0] exp_d;
  logic [59:0] exp_w;
  wbsu_operands_t ops;
  wbsu_instr_t instr;
  wbsu_operands_t opd;
  wbsu_result_t res;
  int num_errors, checked;
  wbsu_issue_model partner (.mclk_in(mclk_in), .issue_in(issue), .word_in(iword),
    .ops_in(ops), .instr_out(instr), .operands_out(opd));
  wbsu_unit uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .extended_model_in(ext),
    .instr_in(instr), .operands_in(opd), .result_out(res));
  function automatic logic [59:0] rotl(logic [59:0] w, int n);
    n = n % 60;
    return (n == 0) ? w : (w << n) | (w >> (60 - n));
  endfunction
  function automatic logic [59:0] sra(logic [59:0] w, int n);
    return (n >= 60) ? {60{w[59]}} : 60'($signed(w) >>> n);
  endfunction
  // reference result; counts go through locals to keep inversions 6 or 12 bits wide
  function automatic logic [59:0] model(logic [5:0] op, logic x, wbsu_operands_t o,
    logic [5:0] jk);
    logic [17:0] b;
    logic [5:0] n6;
    logic [11:0] n12;
    b = o.shift_count_index_register;
    n6 = ~b[5:0];
    n12 = ~b[11:0];
    if (op == 6'h0F) return o.first_source_register ^ ~o.second_source_register;
    if (op == 6'h10) return rotl(o.result_operand_register, jk);
    if (op == 6'h11) return sra(o.result_operand_register, jk);
    if (x && (b == 18'h00000 || b == 18'h3FFFF)) return o.second_source_register;
    if (!b[17]) return rotl(o.second_source_register, b[5:0]);
    if (!x) return (b[10:6] != 5'h1F) ? '0 : sra(o.second_source_register, n6);
    return (b[11:6] != 6'h3F) ? '1 : sra(o.second_source_register, n12);
  endfunction
  // words biased toward all zeros and all ones
  function automatic logic [59:0] rw();
    case ($urandom % 4)
      0: return '0;
      1: return '1;
      default: return 60'({$urandom, $urandom});
    endcase
  endfunction
  // index corners: zeros, in-range negatives, small positives
  function automatic logic [17:0] rix();
    case ($urandom % 5)
      0: return 18'($urandom);
      1: return 18'h3FFC0 | 18'($urandom % 64);
      2: return 18'($urandom % 64);
      3: return ($urandom % 2) ? 18'h3FFFF : 18'h00000;
      default: return 18'h3F000 | 18'($urandom % 4096);
    endcase
  endfunction
  task automatic chk(string name, logic [59:0] seen, logic [59:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  // watchdog well past the 3000-cycle run
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
  initial begin
    logic [5:0] op;
    {rstn_in, ext, issue, iword, ops, exp_v, exp_u, exp_d, exp_w} = '0;
    num_errors = 0;
    checked = 0;
    void'($urandom(88805));
    repeat (3) @(negedge mclk_in);
    rstn_in = 1'b1;
    chk("reset data", res.data, '0);
    chk("reset flags", {res.write_en, res.unsupported, res.dest_des}, '0);
    // back-to-back issue with idle gaps and stray codes
    repeat (3000) begin
      @(negedge mclk_in);
      chk("write_en", res.write_en, exp_v);
      chk("unsupported", res.unsupported, exp_u);
      if (exp_v) chk("dest", res.dest_des, exp_d);
      if (exp_v | exp_u) chk("data", res.data, exp_w);
      op = ($urandom % 8 == 0) ? 6'($urandom) : 6'h0E + 6'($urandom % 6);
      issue = ($urandom % 5) != 0;
      ext = 1'($urandom);
      iword = {op, 9'($urandom)};
      ops = {rw(), rw(), rw(), rix()};
      exp_v = issue && op >= 6'h0F && op <= 6'h12;
      exp_u = issue && !exp_v;
      exp_d = iword[8:6];
      exp_w = exp_u ? '0 : model(op, ext, ops, iword[5:0]);
    end
    test_done();
  end
endmodule
